/* rtl/mgmt_serial_pkg.sv */
// shared constants and types for the management serial link
package mgmt_serial_pkg;

    // frame layout
    localparam logic [5:0] PREAMBLE_LEN = 6'd32;
    localparam logic [31:0] PREAMBLE_WORD = 32'hffffffff;
    localparam logic [1:0] SOF_CODE = 2'b01;
    localparam logic [1:0] OP_READ = 2'b10;
    localparam logic [1:0] OP_WRITE = 2'b01;
    localparam logic [1:0] TA_WRITE = 2'b10;
    localparam logic [1:0] TA_RELEASED = 2'b00;
    localparam int HDR_BITS = 12;
    localparam int DATA_BITS = 16;
    localparam int FRAME_BITS = 64;
    localparam logic [4:0] HDR_LAST = 5'd11;
    localparam logic [4:0] TA_LAST = 5'd1;
    localparam logic [4:0] DATA_LAST = 5'd15;
    localparam logic [5:0] FRAME_LAST = 6'd63;
    localparam logic [5:0] HOST_RELEASE_BIT = 6'd46;
    localparam logic [5:0] READ_DATA_FIRST = 6'd48;

    // address fields
    localparam int MODE_BIT = 2;
    localparam int STD_REG_COUNT = 6;
    localparam int CFG_REG_COUNT = 128;
    localparam logic [6:0] IND_SEL_ADDR = 7'h7c;
    localparam logic [6:0] IND_HI_ADDR = 7'h7d;
    localparam logic [6:0] IND_LO_ADDR = 7'h7e;
    localparam logic [15:0] STD_RESET = 16'h0000;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // link clock timing
    localparam int SYS_PERIOD_NS = 50;
    localparam int MDC_MIN_PERIOD_NS = 400;
    localparam int MDC_HALF_CYCLES =
        (MDC_MIN_PERIOD_NS / 2 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_PRE, ST_SOF, ST_HDR, ST_TA, ST_DATA
    } rx_state_type;

    typedef enum logic [1:0] {
        H_IDLE, H_LOW, H_HIGH
    } host_state_type;

endpackage : mgmt_serial_pkg

/* rtl/mgmt_link_if.sv */
// link wires between management controller and switch device
`timescale 1ns/1ps
interface mgmt_link_if;
    logic mdc;
    logic hostOut;
    logic hostOe;
    logic devOut;
    logic devOe;
    logic mdio;

    // resolved data line level, pulled high when released
    assign mdio = hostOe ? hostOut : (devOe ? devOut : 1'b1);

    modport host (output mdc, output hostOut, output hostOe, input mdio);
    modport device (input mdc, input mdio, output devOut, output devOe);
endinterface : mgmt_link_if

/* rtl/mgmt_serial_device.sv */
// switch-side management serial slave with register store
// Operation
// - 32 ones then 01 open each frame
// - opcodes 10 read, 01 write; turnarounds
// - five-bit address fields, then sixteen data bits
// - address bit 2 low selects standard access
// - standard access ignores address bits 4:3
// - standard access reaches six 16-bit registers
// - address bit 2 high selects extended access
// - extended access ignores address bits 1:0
// - extended address is address[4:3] plus register
// - extended reaches 0x00-0x7F plus indirect standard
// - extended read returns zero upper byte
// - extended write stores only low byte
// - one clock, one data line, both modes
`timescale 1ns/1ps
module mgmt_serial_device
    import mgmt_serial_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    mgmt_link_if.device link,
    output logic wrPulse_ff,
    output logic wrExtended_ff,
    output logic [6:0] wrAddr_ff,
    output logic [15:0] wrData_ff
);

    // link-domain state
    rx_state_type state_ff;
    rx_state_type nxtState;
    logic [4:0] cnt_ff;
    logic [4:0] nxtCnt;
    logic [5:0] ones_ff;
    logic [5:0] nxtOnes;
    logic [HDR_BITS-1:0] hdr_ff;
    logic [HDR_BITS-1:0] nxtHdrReg;
    logic [DATA_BITS-1:0] rx_ff;
    logic [DATA_BITS-1:0] tx_ff;
    logic [DATA_BITS-1:0] nxtTx;
    logic oe_ff;
    logic nxtOe;
    logic out_ff;
    logic nxtOut;
    logic [7:0] cfgMem [CFG_REG_COUNT];
    logic [15:0] phyMem [STD_REG_COUNT];

    // write event handed to the system clock
    logic evToggle_ff;
    logic evExt_ff;
    logic [6:0] evAddr_ff;
    logic [15:0] evData_ff;

    // system-domain synchroniser
    logic evSync1_ff;
    logic evSync2_ff;
    logic evSync3_ff;
    logic evSeen_ff;

    // the line is sampled straight on the link clock
    wire bitIn = link.mdio;
    wire [HDR_BITS-1:0] nxtHdr = {hdr_ff[HDR_BITS-2:0], bitIn};
    wire [DATA_BITS-1:0] nxtRx = {rx_ff[DATA_BITS-2:0], bitIn};

    // decode of the header just completing
    wire [1:0] hOp = nxtHdr[11:10];
    wire [4:0] hPhy = nxtHdr[9:5];
    wire [4:0] hReg = nxtHdr[4:0];
    wire hOpValid = (hOp == OP_READ) || (hOp == OP_WRITE);
    wire hExt = hPhy[MODE_BIT];
    wire [6:0] hCfgAddr = {hPhy[4:3], hReg};
    wire hStdHit = hReg < 5'(STD_REG_COUNT);

    // decode of the held header during data bits
    wire [1:0] cOp = hdr_ff[11:10];
    wire cRead = cOp == OP_READ;
    wire cExt = hdr_ff[5 + MODE_BIT];
    wire [4:0] cReg = hdr_ff[4:0];
    wire [6:0] cCfgAddr = {hdr_ff[9:8], cReg};
    wire cStdHit = cReg < 5'(STD_REG_COUNT);

    // indirect window onto the standard registers
    wire [2:0] indSel = cfgMem[IND_SEL_ADDR][2:0];
    wire indValid = indSel < 3'(STD_REG_COUNT);
    wire [15:0] indData = indValid ? phyMem[indSel] : 16'h0000;

    // read word selection
    wire [15:0] stdRead = hStdHit ? phyMem[hReg[2:0]] : 16'h0000;
    wire [7:0] cfgByte = (hCfgAddr == IND_HI_ADDR) ? indData[15:8] :
                         (hCfgAddr == IND_LO_ADDR) ? indData[7:0] :
                         cfgMem[hCfgAddr];
    wire [15:0] rdWord = hExt ? {8'h00, cfgByte} : stdRead;

    // write commit on the last data bit
    wire lastData = (state_ff == ST_DATA) && (cnt_ff == DATA_LAST);
    wire commit = lastData && (cOp == OP_WRITE);
    wire isIndHi = cCfgAddr == IND_HI_ADDR;
    wire isIndLo = cCfgAddr == IND_LO_ADDR;
    wire cfgWe = commit && cExt && !isIndHi && !isIndLo;
    wire stdWe = commit && !cExt && cStdHit;
    wire hiWe = commit && cExt && isIndHi && indValid;
    wire loWe = commit && cExt && isIndLo && indValid;

    // frame sequencer next state
    always_comb begin
        nxtState = state_ff;
        nxtCnt = cnt_ff + 5'd1;
        nxtOnes = ones_ff;
        nxtHdrReg = hdr_ff;
        nxtTx = tx_ff;
        nxtOe = oe_ff;
        nxtOut = out_ff;
        unique case (state_ff)
            ST_PRE: begin
                if (bitIn) begin
                    if (ones_ff != PREAMBLE_LEN) begin
                        nxtOnes = ones_ff + 6'd1;
                    end
                end else if (ones_ff == PREAMBLE_LEN) begin
                    nxtState = ST_SOF;
                end else begin
                    nxtOnes = '0;
                end
            end
            ST_SOF: begin
                nxtOnes = '0;
                nxtCnt = '0;
                nxtState = bitIn ? ST_HDR : ST_PRE;
            end
            ST_HDR: begin
                nxtHdrReg = nxtHdr;
                if (cnt_ff == HDR_LAST) begin
                    nxtCnt = '0;
                    nxtTx = rdWord;
                    nxtState = hOpValid ? ST_TA : ST_PRE;
                end
            end
            ST_TA: begin
                if (cnt_ff != TA_LAST) begin
                    nxtOe = cRead;
                    nxtOut = 1'b0;
                end else begin
                    nxtCnt = '0;
                    nxtState = ST_DATA;
                    if (cRead) begin
                        nxtOut = tx_ff[DATA_BITS-1];
                        nxtTx = {tx_ff[DATA_BITS-2:0], 1'b0};
                    end
                end
            end
            ST_DATA: begin
                if (cnt_ff == DATA_LAST) begin
                    nxtState = ST_PRE;
                    nxtOnes = '0;
                    nxtOe = 1'b0;
                    nxtOut = 1'b0;
                end else if (cRead) begin
                    nxtOut = tx_ff[DATA_BITS-1];
                    nxtTx = {tx_ff[DATA_BITS-2:0], 1'b0};
                end
            end
            default: begin
                nxtState = ST_PRE;
                nxtOnes = '0;
                nxtOe = 1'b0;
            end
        endcase
    end

    // sequencer registers on the link clock
    always_ff @(posedge link.mdc or posedge reset) begin
        if (reset) begin
            state_ff <= ST_PRE;
            cnt_ff <= '0;
            ones_ff <= '0;
            hdr_ff <= '0;
            tx_ff <= '0;
            oe_ff <= 1'b0;
            out_ff <= 1'b0;
        end else begin
            state_ff <= nxtState;
            cnt_ff <= nxtCnt;
            ones_ff <= nxtOnes;
            hdr_ff <= nxtHdrReg;
            tx_ff <= nxtTx;
            oe_ff <= nxtOe;
            out_ff <= nxtOut;
        end
    end

    // receive shifter for write data
    always_ff @(posedge link.mdc or posedge reset) begin
        if (reset) begin
            rx_ff <= '0;
        end else if (state_ff == ST_DATA) begin
            rx_ff <= nxtRx;
        end
    end

    assign link.devOe = oe_ff;
    assign link.devOut = out_ff;

    // configuration bytes, one per entry
    for (genvar i = 0; i < CFG_REG_COUNT; i++) begin : g_cfg
        always_ff @(posedge link.mdc or posedge reset) begin
            if (reset) begin
                cfgMem[i] <= CFG_RESET;
            end else if (cfgWe && cCfgAddr == 7'(i)) begin
                cfgMem[i] <= nxtRx[7:0];
            end
        end
    end

    // standard registers, direct or through the indirect window
    for (genvar j = 0; j < STD_REG_COUNT; j++) begin : g_std
        always_ff @(posedge link.mdc or posedge reset) begin
            if (reset) begin
                phyMem[j] <= STD_RESET;
            end else if (stdWe && cReg == 5'(j)) begin
                phyMem[j] <= nxtRx;
            end else if (hiWe && indSel == 3'(j)) begin
                phyMem[j][15:8] <= nxtRx[7:0];
            end else if (loWe && indSel == 3'(j)) begin
                phyMem[j][7:0] <= nxtRx[7:0];
            end
        end
    end

    // write event capture, held stable until the next write frame
    always_ff @(posedge link.mdc or posedge reset) begin
        if (reset) begin
            evToggle_ff <= 1'b0;
            evExt_ff <= 1'b0;
            evAddr_ff <= '0;
            evData_ff <= '0;
        end else if (commit) begin
            evToggle_ff <= ~evToggle_ff;
            evExt_ff <= cExt;
            evAddr_ff <= cExt ? cCfgAddr : {2'b00, cReg};
            evData_ff <= cExt ? {8'h00, nxtRx[7:0]} : nxtRx;
        end
    end

    // toggle crossing into the system clock
    wire evNew = (evSync2_ff == evSync3_ff) && (evSync3_ff != evSeen_ff);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            evSync1_ff <= 1'b0;
            evSync2_ff <= 1'b0;
            evSync3_ff <= 1'b0;
            evSeen_ff <= 1'b0;
        end else begin
            evSync1_ff <= evToggle_ff;
            evSync2_ff <= evSync1_ff;
            evSync3_ff <= evSync2_ff;
            evSeen_ff <= evNew ? evSync3_ff : evSeen_ff;
        end
    end

    // write report outputs
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wrPulse_ff <= 1'b0;
            wrExtended_ff <= 1'b0;
            wrAddr_ff <= '0;
            wrData_ff <= '0;
        end else begin
            wrPulse_ff <= evNew;
            if (evNew) begin
                wrExtended_ff <= evExt_ff;
                wrAddr_ff <= evAddr_ff;
                wrData_ff <= evData_ff;
            end
        end
    end

endmodule : mgmt_serial_device

/* rtl/mgmt_serial_host.sv */
// management controller end: clock divider and frame engine
`timescale 1ns/1ps
module mgmt_serial_host
    import mgmt_serial_pkg::*;
#(
    parameter int MDC_HALF = MDC_HALF_CYCLES
)(
    input wire logic clk_sys,
    input wire logic reset,
    mgmt_link_if.host link,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [4:0] reqPhyAddr,
    input wire logic [4:0] reqRegAddr,
    input wire logic [15:0] reqData,
    output logic reqReady_ff,
    output logic respValid_ff,
    output logic [15:0] respData_ff
);

    localparam logic [7:0] HALF_LAST = 8'(MDC_HALF - 1);

    host_state_type state_ff;
    host_state_type nxtState;
    logic [7:0] div_ff;
    logic [7:0] nxtDiv;
    logic [5:0] bit_ff;
    logic [5:0] nxtBit;
    logic [FRAME_BITS-1:0] tx_ff;
    logic [FRAME_BITS-1:0] nxtTx;
    logic [15:0] rx_ff;
    logic [15:0] nxtRx;
    logic mdc_ff;
    logic nxtMdc;
    logic out_ff;
    logic nxtOut;
    logic oe_ff;
    logic nxtOe;
    logic write_ff;
    logic nxtWrite;
    logic nxtReady;
    logic nxtRespValid;
    logic [15:0] nxtRespData;
    logic in1_ff;
    logic in2_ff;
    logic in3_ff;
    logic inFilt_ff;

    // whole frame, first bit on top
    wire [1:0] reqOp = reqWrite ? OP_WRITE : OP_READ;
    wire [1:0] reqTa = reqWrite ? TA_WRITE : TA_RELEASED;
    wire [15:0] reqWord = reqWrite ? reqData : 16'h0000;
    wire [FRAME_BITS-1:0] frameWord = {PREAMBLE_WORD, SOF_CODE, reqOp,
                                       reqPhyAddr, reqRegAddr, reqTa,
                                       reqWord};
    wire [5:0] bitNext = bit_ff + 6'd1;
    wire halfDone = div_ff == HALF_LAST;
    wire takeRx = !write_ff && (bit_ff >= READ_DATA_FIRST);

    // divider and bit sequencer next state
    always_comb begin
        nxtState = state_ff;
        nxtDiv = div_ff + 8'd1;
        nxtBit = bit_ff;
        nxtTx = tx_ff;
        nxtRx = rx_ff;
        nxtMdc = mdc_ff;
        nxtOut = out_ff;
        nxtOe = oe_ff;
        nxtWrite = write_ff;
        nxtReady = reqReady_ff;
        nxtRespValid = 1'b0;
        nxtRespData = respData_ff;
        unique case (state_ff)
            H_IDLE: begin
                nxtDiv = '0;
                if (reqValid) begin
                    nxtState = H_LOW;
                    nxtBit = '0;
                    nxtTx = frameWord;
                    nxtRx = '0;
                    nxtOut = frameWord[FRAME_BITS-1];
                    nxtOe = 1'b1;
                    nxtWrite = reqWrite;
                    nxtReady = 1'b0;
                end
            end
            H_LOW: begin
                if (halfDone) begin
                    nxtDiv = '0;
                    nxtState = H_HIGH;
                    nxtMdc = 1'b1;
                    if (takeRx) begin
                        nxtRx = {rx_ff[14:0], inFilt_ff};
                    end
                end
            end
            H_HIGH: begin
                if (halfDone) begin
                    nxtDiv = '0;
                    nxtMdc = 1'b0;
                    if (bit_ff == FRAME_LAST) begin
                        nxtState = H_IDLE;
                        nxtOe = 1'b0;
                        nxtOut = 1'b0;
                        nxtReady = 1'b1;
                        nxtRespValid = 1'b1;
                        nxtRespData = rx_ff;
                    end else begin
                        nxtState = H_LOW;
                        nxtBit = bitNext;
                        nxtTx = {tx_ff[FRAME_BITS-2:0], 1'b0};
                        nxtOut = tx_ff[FRAME_BITS-2];
                        nxtOe = write_ff || (bitNext < HOST_RELEASE_BIT);
                    end
                end
            end
            default: begin
                nxtState = H_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_ff <= H_IDLE;
            div_ff <= '0;
            bit_ff <= '0;
            tx_ff <= '0;
            rx_ff <= '0;
            mdc_ff <= 1'b0;
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
            write_ff <= 1'b0;
            reqReady_ff <= 1'b1;
            respValid_ff <= 1'b0;
            respData_ff <= '0;
        end else begin
            state_ff <= nxtState;
            div_ff <= nxtDiv;
            bit_ff <= nxtBit;
            tx_ff <= nxtTx;
            rx_ff <= nxtRx;
            mdc_ff <= nxtMdc;
            out_ff <= nxtOut;
            oe_ff <= nxtOe;
            write_ff <= nxtWrite;
            reqReady_ff <= nxtReady;
            respValid_ff <= nxtRespValid;
            respData_ff <= nxtRespData;
        end
    end

    // data line input: three stages, accepted when the last two agree
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            in1_ff <= 1'b1;
            in2_ff <= 1'b1;
            in3_ff <= 1'b1;
            inFilt_ff <= 1'b1;
        end else begin
            in1_ff <= link.mdio;
            in2_ff <= in1_ff;
            in3_ff <= in2_ff;
            inFilt_ff <= (in2_ff == in3_ff) ? in3_ff : inFilt_ff;
        end
    end

    assign link.mdc = mdc_ff;
    assign link.hostOut = out_ff;
    assign link.hostOe = oe_ff;

endmodule : mgmt_serial_host

/* bench/mgmt_serial_sva.sv */
// link wire assertions for the management serial pair
`timescale 1ns/1ps
module mgmt_serial_sva #(
    parameter int MDC_HALF = 4
)(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic mdc,
    input wire logic hostOut,
    input wire logic hostOe,
    input wire logic devOut,
    input wire logic devOe,
    input wire logic mdio
);
    localparam int BC = 2 * MDC_HALF;
    logic [9:0] sinceOe_ff;
    logic [9:0] nxt_sinceOe;
    logic [7:0] hiCnt_ff;
    logic [7:0] nxt_hiCnt;
    logic [9:0] drvCnt_ff;
    logic [9:0] nxt_drvCnt;
    int since;

    // run lengths of host drive, clock high time and device drive
    assign nxt_sinceOe = hostOe ? sinceOe_ff + 10'h001 : 10'h000;
    assign nxt_hiCnt = mdc ? hiCnt_ff + 8'h01 : 8'h00;
    assign nxt_drvCnt = devOe ? drvCnt_ff + 10'h001 : 10'h000;
    assign since = int'(sinceOe_ff);
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sinceOe_ff <= 10'h000;
            hiCnt_ff <= 8'h00;
            drvCnt_ff <= 10'h000;
        end else begin
            sinceOe_ff <= nxt_sinceOe;
            hiCnt_ff <= nxt_hiCnt;
            drvCnt_ff <= nxt_drvCnt;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    no_dual_drive_a: assert property (!(hostOe && devOe))
        else $error("both ends drive the data line");
    pre_ones_a: assert property (
        hostOe && since < 32 * BC |-> hostOut)
        else $error("preamble bit not one");
    sof_code_a: assert property (
        hostOe && since >= 32 * BC && since < 34 * BC
        |-> hostOut == (since >= 33 * BC))
        else $error("start pattern wrong");
    wr_turn_a: assert property (
        hostOe && since >= 46 * BC && since < 48 * BC
        |-> hostOut == (since < 47 * BC))
        else $error("write turnaround wrong");
    frame_len_a: assert property (
        $fell(hostOe) |-> since == 46 * BC || since == 64 * BC)
        else $error("host drive length wrong");
    mdc_half_a: assert property (
        $fell(mdc) |-> int'(hiCnt_ff) == MDC_HALF)
        else $error("link clock high time wrong");
    host_edge_a: assert property (
        hostOe && $changed(hostOut) |-> !mdc)
        else $error("host data moved while clock high");
    dev_edge_a: assert property (
        devOe && $changed(devOut) |-> mdc)
        else $error("device data moved while clock low");
    dev_turn_a: assert property (
        $rose(devOe) |-> !devOut && !hostOe && !$past(hostOe, 2))
        else $error("device turnaround wrong");
    dev_len_a: assert property (
        $fell(devOe) |-> int'(drvCnt_ff) == 17 * BC)
        else $error("device drive length wrong");
    ta_line_a: assert property (
        $rose(devOe) |-> !mdio)
        else $error("read turnaround line not low");

    read_turn_c: cover property ($rose(devOe));
    write_end_c: cover property ($fell(hostOe) && since == 64 * BC);
    clock_run_c: cover property ($fell(mdc));
endmodule : mgmt_serial_sva

/* bench/mgmt_serial_register_access_test.sv */
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
module mgmt_serial_register_access_test;
    import mgmt_serial_pkg::*;
    localparam int HALF = 4;
    localparam int LATENCY = 64 * 2 * HALF + 1;
    logic clk_sys;
    logic reset;
    logic reqValid;
    logic reqWrite;
    logic [4:0] reqPhyAddr;
    logic [4:0] reqRegAddr;
    logic [15:0] reqData;
    logic reqReady;
    logic respValid;
    logic [15:0] respData;
    logic wrPulse;
    logic wrExtended;
    logic [6:0] wrAddr;
    logic [15:0] wrData;
    logic wrPulseB;
    logic wrExtendedB;
    logic [6:0] wrAddrB;
    logic [15:0] wrDataB;
    logic [63:0] frameSeen;
    logic [15:0] stdVal [0:5];
    int wrCnt = 0;
    int wrCntB = 0;
    int fails = 0;
    int n_checks = 0;

    mgmt_link_if link();
    mgmt_link_if linkB();
    mgmt_serial_host #(.MDC_HALF(HALF)) u_mgmt_serial_host (
        .clk_sys(clk_sys), .reset(reset), .link(link),
        .reqValid(reqValid), .reqWrite(reqWrite),
        .reqPhyAddr(reqPhyAddr), .reqRegAddr(reqRegAddr),
        .reqData(reqData), .reqReady_ff(reqReady),
        .respValid_ff(respValid), .respData_ff(respData));
    mgmt_serial_device u_mgmt_serial_device (
        .clk_sys(clk_sys), .reset(reset), .link(link),
        .wrPulse_ff(wrPulse), .wrExtended_ff(wrExtended),
        .wrAddr_ff(wrAddr), .wrData_ff(wrData));
    mgmt_serial_device u_mgmt_serial_device_b (
        .clk_sys(clk_sys), .reset(reset), .link(linkB),
        .wrPulse_ff(wrPulseB), .wrExtended_ff(wrExtendedB),
        .wrAddr_ff(wrAddrB), .wrData_ff(wrDataB));
    mgmt_serial_sva #(.MDC_HALF(HALF)) u_mgmt_serial_sva (
        .clk_sys(clk_sys), .reset(reset), .mdc(link.mdc),
        .hostOut(link.hostOut), .hostOe(link.hostOe),
        .devOut(link.devOut), .devOe(link.devOe), .mdio(link.mdio));

    // system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // wire image of each frame and tallies of write reports
    always @(posedge link.mdc) frameSeen <= {frameSeen[62:0], link.mdio};
    always @(posedge clk_sys) begin
        if (wrPulse === 1'b1) wrCnt <= wrCnt + 1;
        if (wrPulseB === 1'b1) wrCntB <= wrCntB + 1;
    end

    task automatic check_val(input string what, input logic [63:0] exp,
        input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic check_flag(input string what, input logic exp,
        input logic got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : check_flag

    // one request; checks timing, wire image, idle line and answer
    task automatic do_frame(input logic wr, input logic [4:0] phy,
        input logic [4:0] regAddr, input logic [15:0] data);
        int n;
        logic [63:0] expWire;
        n = 0;
        expWire = {PREAMBLE_WORD, SOF_CODE, wr ? OP_WRITE : OP_READ, phy,
            regAddr, TA_WRITE, data};
        @(posedge clk_sys);
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqPhyAddr <= phy;
        reqRegAddr <= regAddr;
        reqData <= data;
        @(posedge clk_sys);
        reqValid <= 1'b0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n == 1) check_flag("ready", 1'b0, reqReady);
        end while (respValid !== 1'b1 && n < 2 * LATENCY);
        // the loop sees respValid just after its launch edge and counts from the
        // edge where the host samples reqValid, one edge after the bench drives it
        check_val("latency", 64'(LATENCY), 64'(n + 1));
        check_flag("ready back", 1'b1, reqReady);
        check_val("wire", expWire, frameSeen);
        check_val("answer", 64'(wr ? 16'h0000 : data), 64'(respData));
        check_flag("clock idle", 1'b0, link.mdc);
        check_flag("line idle", 1'b1, link.mdio);
    endtask : do_frame

    task automatic do_write(input logic [4:0] phy, input logic [4:0] regAddr,
        input logic [15:0] data, input logic ext, input logic [6:0] addr,
        input logic [15:0] stored);
        int cnt0;
        cnt0 = wrCnt;
        do_frame(1'b1, phy, regAddr, data);
        repeat (8) @(posedge clk_sys);
        check_val("writes", 64'(cnt0 + 1), 64'(wrCnt));
        check_flag("mode", ext, wrExtended);
        check_val("address", 64'(addr), 64'(wrAddr));
        check_val("data", 64'(stored), 64'(wrData));
    endtask : do_write

    task automatic test_std();
        for (int i = 0; i < 6; i++) begin
            stdVal[i] = 16'ha5c3 ^ {4{4'(i)}};
            do_write({2'(i), 3'b001}, 5'(i), stdVal[i], 1'b0, 7'(i),
                stdVal[i]);
        end
        for (int i = 0; i < 6; i++) begin
            do_frame(1'b0, {~2'(i), 3'b010}, 5'(i), stdVal[i]);
        end
        do_write(5'h00, 5'h06, 16'hbeef, 1'b0, 7'h06, 16'hbeef);
        do_frame(1'b0, 5'h18, 5'h06, 16'h0000);
        $display("test std done");
    endtask : test_std

    task automatic test_ext();
        logic [4:0] phyT [3] = '{5'b00100, 5'b11111, 5'b01110};
        logic [4:0] regT [3] = '{5'h00, 5'h1f, 5'h05};
        logic [15:0] datT [3] = '{16'hff5a, 16'h12c3, 16'h8077};
        for (int i = 0; i < 3; i++) begin
            do_write(phyT[i], regT[i], datT[i], 1'b1, {phyT[i][4:3], regT[i]},
                {8'h00, datT[i][7:0]});
            do_frame(1'b0, phyT[i] ^ 5'b00011, regT[i],
                {8'h00, datT[i][7:0]});
        end
        $display("test ext done");
    endtask : test_ext

    task automatic test_indirect();
        do_write(5'h1c, 5'h1c, 16'hff02, 1'b1, 7'h7c, 16'h0002);
        do_frame(1'b0, 5'h1d, 5'h1d, {8'h00, stdVal[2][15:8]});
        do_frame(1'b0, 5'h1e, 5'h1e, {8'h00, stdVal[2][7:0]});
        do_write(5'h1e, 5'h1e, 16'h3c99, 1'b1, 7'h7e, 16'h0099);
        do_frame(1'b0, 5'h00, 5'h02, {stdVal[2][15:8], 8'h99});
        do_write(5'h1c, 5'h1c, 16'h0007, 1'b1, 7'h7c, 16'h0007);
        do_frame(1'b0, 5'h1d, 5'h1d, 16'h0000);
        $display("test indirect done");
    endtask : test_indirect

    // bench-made frame on the second link, 80 ns link clock
    task automatic send_raw(input logic [63:0] f);
        #7; // keep the link clock off the system clock's phase
        linkB.hostOe <= 1'b1;
        for (int i = 63; i >= 0; i--) begin
            linkB.hostOut <= f[i];
            #40 linkB.mdc <= 1'b1;
            #40 linkB.mdc <= 1'b0;
        end
        #40 linkB.hostOe <= 1'b0;
        repeat (10) @(posedge clk_sys);
    endtask : send_raw

    task automatic test_refused();
        int cnt0;
        cnt0 = wrCntB;
        send_raw({PREAMBLE_WORD, SOF_CODE, 2'b11, 10'h090, 18'h200aa});
        check_val("bad opcode", 64'(cnt0), 64'(wrCntB));
        send_raw({32'h7fffffff, SOF_CODE, OP_WRITE, 10'h090, 18'h200aa});
        check_val("short preamble", 64'(cnt0), 64'(wrCntB));
        send_raw({PREAMBLE_WORD, SOF_CODE, OP_WRITE, 10'h290, 18'h27755});
        check_val("good frame", 64'(cnt0 + 1), 64'(wrCntB));
        check_val("good address", 64'(7'h50), 64'(wrAddrB));
        check_flag("good mode", 1'b1, wrExtendedB);
        check_val("good data", 64'(16'h0055), 64'(wrDataB));
        $display("test refused done");
    endtask : test_refused

    task automatic close_out();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    // main sequence
    initial begin
        reset = 1'b1;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqPhyAddr = 5'h00;
        reqRegAddr = 5'h00;
        reqData = 16'h0000;
        linkB.mdc = 1'b0;
        linkB.hostOut = 1'b1;
        linkB.hostOe = 1'b0;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        test_std();
        test_ext();
        test_indirect();
        test_refused();
        close_out();
    end

    // watchdog against a hang
    initial begin
        repeat (30000) @(posedge clk_sys);
        fails++;
        close_out();
    end
endmodule : mgmt_serial_register_access_test
